// File: adcc_pkg.sv
// Shared constants, register map and types of the converter calibration control.
package adcc_pkg;

  // Byte offsets of the registers on the bus.
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_RATE = 8'h08;
  localparam logic [7:0] ADDR_DATA0 = 8'h0c;
  localparam logic [7:0] ADDR_DATA1 = 8'h10;
  localparam logic [7:0] ADDR_OFS0 = 8'h14;
  localparam logic [7:0] ADDR_GAIN0 = 8'h18;
  localparam logic [7:0] ADDR_OFS1 = 8'h1c;
  localparam logic [7:0] ADDR_GAIN1 = 8'h20;

  // Converter mode control register fields.
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 3;
  localparam int EN_PRI_BIT = 4;
  localparam int EN_AUX_BIT = 5;

  // Mode codes; codes with the top bit set are calibrations.
  localparam logic [2:0] MD_PDOWN = 3'h0;
  localparam logic [2:0] MD_IDLE = 3'h1;
  localparam logic [2:0] MD_SINGLE = 3'h2;
  localparam logic [2:0] MD_CONT = 3'h3;
  localparam logic [2:0] MD_CAL_INT_ZERO = 3'h4;
  localparam logic [2:0] MD_CAL_INT_FULL = 3'h5;
  localparam logic [2:0] MD_CAL_SYS_ZERO = 3'h6;
  localparam logic [2:0] MD_CAL_SYS_FULL = 3'h7;
  localparam int KIND_FULL_BIT = 0;
  localparam int KIND_SYS_BIT = 1;
  localparam int MODE_CAL_BIT = 2;

  // Converter status register fields.
  localparam int ST_PRIMARY_READY_FLAG_BIT = 0;
  localparam int ST_AUXILIARY_READY_FLAG_BIT = 1;
  localparam int ST_NOREF_BIT = 2;
  localparam int ST_PRIMARY_CALIBRATION_ERROR_FLAG_BIT = 3;
  localparam int ST_AUXILIARY_CALIBRATION_ERROR_FLAG_BIT = 4;
  localparam int ST_BUSY_BIT = 5;

  // Reset values and fixed words.
  localparam logic [7:0] RATE_RESET = 8'h45;
  localparam logic [7:0] RATE_SLOWEST = 8'hff;
  localparam logic [15:0] DATA_NOREF = 16'hffff;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;

  // Gain normalisation: a stored gain of 16'h8000 means unity.
  localparam logic [17:0] GAIN_TWO = 18'h10000;
  localparam int GAIN_SHIFT = 15;

  // Modulator input selection codes.
  localparam logic [1:0] SEL_PINS = 2'h0;
  localparam logic [1:0] SEL_ZERO = 2'h1;
  localparam logic [1:0] SEL_FULL = 2'h2;

  // AHB transfer type bit that marks an active transfer.
  localparam int HTRANS_ACTIVE_BIT = 1;

  typedef struct packed {
    logic valid;
    logic [15:0] word;
  } adcc_sample_t;

  typedef struct packed {
    logic [15:0] offset;
    logic [15:0] gain;
  } adcc_coef_t;

  typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_CAL} adcc_state_t;

endpackage

// File: adcc_correct.sv
// Offset subtraction and normalised gain scaling of one filter word.
`timescale 1ns/1ps
module adcc_correct
  import adcc_pkg::*;
(
  input logic [15:0] word,
  input logic [15:0] offset,
  input logic [15:0] gain,
  output logic [15:0] result
);

  logic signed [16:0] diff;
  logic signed [17:0] norm;
  logic signed [35:0] prod;
  logic signed [35:0] scaled;

  // Subtract the offset first, then scale by the normalised gain.
  always_comb begin
    diff = $signed({1'b0, word}) - $signed({1'b0, offset}); // R11
    norm = $signed(GAIN_TWO) - $signed({2'b00, gain}); // R10
    prod = diff * norm; // R11
    scaled = prod >>> GAIN_SHIFT;
    if (scaled < 36'sh0) begin
      result = 16'h0000;
    end else if (scaled > 36'sh0ffff) begin
      result = 16'hffff;
    end else begin
      result = scaled[15:0];
    end
  end

endmodule

// File: adcc_top.sv
// Calibration control of the primary and auxiliary converters, AHB-Lite slave.
//
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps

// What this block does
// R1 - Four calibration modes are started by writing the mode field.
// R2 - After reset the factory offset and gain words of both converters load.
// R3 - Each converter has its own offset and gain registers.
// R4 - A calibration only overwrites a converter's words if it is enabled.
// R5 - A zero-scale result is written to that converter's offset register.
// R6 - A full-scale result is written to that converter's gain register.
// R7 - Internal calibrations steer the modulator to the matching reference.
// R8 - For system calibration the system applies the level before the start.
// R9 - Calibration conversions always run at the slowest filter rate.
// R10 - The stored gain is normalised before it scales filter words.
// R11 - Correction subtracts the offset and then multiplies by the gain.
// R12 - Software should calibrate zero scale before full scale.
// R13 - The ready flag is set when a calibration finishes, as for a result.
// R14 - A missing reference during calibration blocks the update and flags it.
// R15 - Calibration results never reach the converter data registers.
module adcc_top
  import adcc_pkg::*;
(
  input logic hclk,
  input logic hresetn,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input adcc_coef_t factory_pri,
  input adcc_coef_t factory_aux,
  input adcc_sample_t sample_pri,
  input adcc_sample_t sample_aux,
  input logic missing_ref,
  output logic [1:0] mod_sel_pri,
  output logic [1:0] mod_sel_aux,
  output logic [7:0] filter_rate,
  output logic run_pri,
  output logic run_aux
);

  // Bus state.
  logic wr_pend_r;
  logic wr_pend_nxt;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_addr_nxt;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;
  logic [31:0] rd_word;
  logic addr_ok;

  // Control and status state.
  adcc_state_t state_r;
  adcc_state_t state_nxt;
  logic [2:0] mode_r;
  logic [2:0] mode_nxt;
  logic [1:0] en_r;
  logic [1:0] en_nxt;
  logic [7:0] rate_r;
  logic [7:0] rate_nxt;
  logic [1:0] kind_r;
  logic [1:0] kind_nxt;
  logic [1:0] tgt_r;
  logic [1:0] tgt_nxt;
  logic [1:0] noref_seen_r;
  logic [1:0] noref_seen_nxt;
  logic [1:0] rdy_r;
  logic [1:0] rdy_nxt;
  logic [1:0] err_r;
  logic [1:0] err_nxt;
  adcc_coef_t coef_r [2];
  adcc_coef_t coef_nxt [2];
  logic [15:0] data_r [2];
  logic [15:0] data_nxt [2];

  // Output flops.
  logic [1:0] sel_r [2];
  logic [1:0] sel_nxt [2];
  logic [7:0] rate_out_r;
  logic [7:0] rate_out_nxt;
  logic [1:0] run_r;
  logic [1:0] run_nxt;
  logic run_one_r;
  logic resp_r;

  // Per-converter views.
  adcc_sample_t smp [2];
  adcc_coef_t fac [2];
  logic [15:0] corr [2];
  logic [15:0] bus_coef_word;
  logic conv_mode;

  assign smp[0] = sample_pri;
  assign smp[1] = sample_aux;
  assign fac[0] = factory_pri;
  assign fac[1] = factory_aux;

  // True when a byte address hits the given register word.
  function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
    hit = (a[31:8] == 24'h000000) && (a[7:0] == off);
  endfunction

  // Correction datapath of the primary converter.
  adcc_correct u_corr_pri (
    .word(smp[0].word),
    .offset(coef_r[0].offset),
    .gain(coef_r[0].gain),
    .result(corr[0])
  );

  // Correction datapath of the auxiliary converter.
  adcc_correct u_corr_aux (
    .word(smp[1].word),
    .offset(coef_r[1].offset),
    .gain(coef_r[1].gain),
    .result(corr[1])
  );

  // Read multiplexer; unmapped addresses read as zero.
  always_comb begin
    rd_word = WORD_ZERO;
    if (hit(haddr, ADDR_MODE)) begin
      rd_word[MODE_LSB +: MODE_W] = mode_r;
      rd_word[EN_PRI_BIT] = en_r[0];
      rd_word[EN_AUX_BIT] = en_r[1];
    end else if (hit(haddr, ADDR_STAT)) begin
      rd_word[ST_PRIMARY_READY_FLAG_BIT] = rdy_r[0];
      rd_word[ST_AUXILIARY_READY_FLAG_BIT] = rdy_r[1];
      rd_word[ST_NOREF_BIT] = missing_ref;
      rd_word[ST_PRIMARY_CALIBRATION_ERROR_FLAG_BIT] = err_r[0];
      rd_word[ST_AUXILIARY_CALIBRATION_ERROR_FLAG_BIT] = err_r[1];
      rd_word[ST_BUSY_BIT] = (state_r == ST_CAL);
    end else if (hit(haddr, ADDR_RATE)) begin
      rd_word[7:0] = rate_r;
    end else if (hit(haddr, ADDR_DATA0)) begin
      rd_word[15:0] = data_r[0];
    end else if (hit(haddr, ADDR_DATA1)) begin
      rd_word[15:0] = data_r[1];
    end else if (hit(haddr, ADDR_OFS0)) begin
      rd_word[15:0] = coef_r[0].offset; // R3
    end else if (hit(haddr, ADDR_GAIN0)) begin
      rd_word[15:0] = coef_r[0].gain;
    end else if (hit(haddr, ADDR_OFS1)) begin
      rd_word[15:0] = coef_r[1].offset; // R3
    end else if (hit(haddr, ADDR_GAIN1)) begin
      rd_word[15:0] = coef_r[1].gain;
    end
  end

  // Address phase capture; reads answer in the next cycle, no wait states.
  always_comb begin
    addr_ok = hsel && htrans[HTRANS_ACTIVE_BIT] && hready;
    wr_pend_nxt = addr_ok && hwrite;
    wr_addr_nxt = addr_ok ? haddr[7:0] : wr_addr_r;
    hrdata_nxt = (addr_ok && !hwrite) ? rd_word : WORD_ZERO;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h00000000;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  // Register writes, calibration sequencing and conversion capture.
  always_comb begin
    state_nxt = state_r;
    mode_nxt = mode_r;
    en_nxt = en_r;
    rate_nxt = rate_r;
    kind_nxt = kind_r;
    tgt_nxt = tgt_r;
    noref_seen_nxt = noref_seen_r;
    rdy_nxt = rdy_r;
    err_nxt = err_r;
    coef_nxt = coef_r;
    data_nxt = data_r;
    bus_coef_word = hwdata[15:0];
    conv_mode = (mode_r == MD_SINGLE) || (mode_r == MD_CONT);

    // Software writes; the data phase of a write lasts one cycle.
    if (wr_pend_r) begin
      case (wr_addr_r)
        ADDR_MODE: begin
          if (state_r != ST_CAL) begin
            en_nxt = {hwdata[EN_AUX_BIT], hwdata[EN_PRI_BIT]};
            mode_nxt = hwdata[MODE_LSB +: MODE_W];
            tgt_nxt = 2'b00;
            if (hwdata[MODE_LSB + MODE_CAL_BIT]) begin
              // Start one of the four calibrations. R1
              kind_nxt = hwdata[MODE_LSB +: 2];
              tgt_nxt = {hwdata[EN_AUX_BIT], hwdata[EN_PRI_BIT]}; // R4
              noref_seen_nxt = 2'b00;
              if (tgt_nxt != 2'b00) begin
                state_nxt = ST_CAL;
              end else begin
                mode_nxt = MD_IDLE; // R4
              end
            end else if (hwdata[MODE_LSB +: MODE_W] == MD_SINGLE) begin
              tgt_nxt = {hwdata[EN_AUX_BIT], hwdata[EN_PRI_BIT]};
            end
          end
        end
        ADDR_STAT: begin
          rdy_nxt[0] = rdy_r[0] & ~hwdata[ST_PRIMARY_READY_FLAG_BIT];
          rdy_nxt[1] = rdy_r[1] & ~hwdata[ST_AUXILIARY_READY_FLAG_BIT];
          err_nxt[0] = err_r[0] & ~hwdata[ST_PRIMARY_CALIBRATION_ERROR_FLAG_BIT];
          err_nxt[1] = err_r[1] & ~hwdata[ST_AUXILIARY_CALIBRATION_ERROR_FLAG_BIT];
        end
        ADDR_RATE: rate_nxt = hwdata[7:0];
        ADDR_OFS0: coef_nxt[0].offset = bus_coef_word;
        ADDR_GAIN0: coef_nxt[0].gain = bus_coef_word;
        ADDR_OFS1: coef_nxt[1].offset = bus_coef_word;
        ADDR_GAIN1: coef_nxt[1].gain = bus_coef_word;
        default: begin
        end
      endcase
    end

    // Hardware events; they come after the clears so a set always wins.
    case (state_r)
      ST_LOAD: begin
        for (int i = 0; i < 2; i++) begin
          coef_nxt[i] = fac[i]; // R2
        end
        state_nxt = ST_IDLE;
      end
      ST_CAL: begin
        for (int i = 0; i < 2; i++) begin
          if (tgt_r[i]) begin
            noref_seen_nxt[i] = noref_seen_r[i] | missing_ref;
            if (smp[i].valid) begin
              if (noref_seen_r[i] || missing_ref) begin
                err_nxt[i] = 1'b1; // R14
              end else if (kind_r[KIND_FULL_BIT]) begin
                coef_nxt[i].gain = smp[i].word; // R6
              end else begin
                coef_nxt[i].offset = smp[i].word; // R5
              end
              rdy_nxt[i] = 1'b1; // R13
              tgt_nxt[i] = 1'b0;
            end
          end
        end
        // The data registers are left alone during calibration. R15
        if (tgt_nxt == 2'b00) begin
          state_nxt = ST_IDLE;
          mode_nxt = MD_IDLE;
        end
      end
      ST_IDLE: begin
        if (conv_mode) begin
          for (int i = 0; i < 2; i++) begin
            if (en_r[i] && smp[i].valid) begin
              data_nxt[i] = missing_ref ? DATA_NOREF : corr[i]; // R11
              rdy_nxt[i] = 1'b1;
              tgt_nxt[i] = 1'b0;
            end
          end
          if ((mode_r == MD_SINGLE) && (tgt_nxt == 2'b00)) begin
            mode_nxt = MD_IDLE;
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_LOAD;
      mode_r <= MD_IDLE;
      en_r <= 2'b00;
      rate_r <= RATE_RESET;
      kind_r <= 2'b00;
      tgt_r <= 2'b00;
      noref_seen_r <= 2'b00;
      rdy_r <= 2'b00;
      err_r <= 2'b00;
      for (int i = 0; i < 2; i++) begin
        coef_r[i] <= '0;
        data_r[i] <= 16'h0000;
      end
    end else begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
      en_r <= en_nxt;
      rate_r <= rate_nxt;
      kind_r <= kind_nxt;
      tgt_r <= tgt_nxt;
      noref_seen_r <= noref_seen_nxt;
      rdy_r <= rdy_nxt;
      err_r <= err_nxt;
      coef_r <= coef_nxt;
      data_r <= data_nxt;
    end
  end

  // Datapath controls follow the next state so they change with it.
  always_comb begin
    rate_out_nxt = rate_nxt;
    if (state_nxt == ST_CAL) begin
      rate_out_nxt = RATE_SLOWEST; // R9
    end
    for (int i = 0; i < 2; i++) begin
      sel_nxt[i] = SEL_PINS;
      run_nxt[i] = en_nxt[i] &&
        ((mode_nxt == MD_CONT) || ((mode_nxt == MD_SINGLE) && tgt_nxt[i]));
      if ((state_nxt == ST_CAL) && tgt_nxt[i]) begin
        run_nxt[i] = 1'b1;
        if (!kind_nxt[KIND_SYS_BIT]) begin
          sel_nxt[i] = kind_nxt[KIND_FULL_BIT] ? SEL_FULL : SEL_ZERO; // R7
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rate_out_r <= RATE_RESET;
      run_r <= 2'b00;
      for (int i = 0; i < 2; i++) begin
        sel_r[i] <= SEL_PINS;
      end
    end else begin
      rate_out_r <= rate_out_nxt;
      run_r <= run_nxt;
      sel_r <= sel_nxt;
    end
  end

  // Ports; the slave never stalls and always answers OKAY.
  assign hrdata = hrdata_r;
  assign hreadyout = run_one_r;
  assign hresp = resp_r;
  assign mod_sel_pri = sel_r[0];
  assign mod_sel_aux = sel_r[1];
  assign filter_rate = rate_out_r;
  assign run_pri = run_r[0];
  assign run_aux = run_r[1];

  // Constant bus answer flops.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_one_r <= 1'b1;
      resp_r <= 1'b0;
    end else begin
      run_one_r <= 1'b1;
      resp_r <= 1'b0;
    end
  end

endmodule

// File: adcc_notes_fix.sv
// Intentionally empty companion file.
`timescale 1ns/1ps

// File: adcc_chk.sv
// Concurrent checks on the calibration control outputs.
`timescale 1ns/1ps
module adcc_chk
  import adcc_pkg::*;
(
  input logic hclk,
  input logic hresetn,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [31:0] hwdata,
  input logic hready,
  input logic [1:0] mod_sel_pri,
  input logic [1:0] mod_sel_aux,
  input logic [7:0] filter_rate,
  input logic run_pri,
  input logic run_aux
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic mode_wr;
  // A mode write taken on the bus while neither converter runs.
  assign mode_wr = hsel && htrans[HTRANS_ACTIVE_BIT] && hready && hwrite &&
    haddr == {24'h000000, ADDR_MODE} && !run_pri && !run_aux;

  slow_pri_a: assert property (
    mod_sel_pri != SEL_PINS |-> filter_rate == RATE_SLOWEST)
    else $error("rate not slowest in primary calibration");
  slow_aux_a: assert property (
    mod_sel_aux != SEL_PINS |-> filter_rate == RATE_SLOWEST)
    else $error("rate not slowest in auxiliary calibration");
  sel_run_a: assert property (
    mod_sel_pri != SEL_PINS |-> run_pri)
    else $error("reference selected while primary idle");
  sel_same_a: assert property (
    mod_sel_pri != SEL_PINS && mod_sel_aux != SEL_PINS |->
    mod_sel_pri == mod_sel_aux)
    else $error("converters steered to different references");
  zero_sel_a: assert property (
    mode_wr ##1 (hwdata[2:0] == MD_CAL_INT_ZERO && hwdata[EN_PRI_BIT])
    |=> mod_sel_pri == SEL_ZERO)
    else $error("zero reference not selected");
  full_sel_a: assert property (
    mode_wr ##1 (hwdata[2:0] == MD_CAL_INT_FULL && hwdata[EN_PRI_BIT])
    |=> mod_sel_pri == SEL_FULL)
    else $error("full reference not selected");
  start_slow_a: assert property (
    mode_wr ##1 (hwdata[MODE_CAL_BIT] && hwdata[EN_AUX_BIT:EN_PRI_BIT] != 0)
    |=> filter_rate == RATE_SLOWEST [*2])
    else $error("calibration start without slowest rate");
  reset_out_a: assert property (
    $rose(hresetn) |-> !run_pri && !run_aux && filter_rate == RATE_RESET)
    else $error("outputs wrong after reset");
endmodule

// File: adcc_filt_model.sv
// Behavioural filter datapath model that answers the converters' runs.
`timescale 1ns/1ps
module adcc_filt_model
  import adcc_pkg::*;
(
  input logic clk,
  input logic rstn,
  input logic run_pri,
  input logic run_aux,
  input logic [1:0] mod_sel_pri,
  input logic [1:0] mod_sel_aux,
  input logic [15:0] pin_word,
  output adcc_sample_t sample_pri,
  output adcc_sample_t sample_aux
);
  logic [2:0] cnt_r;
  // Reading of the chosen input; the auxiliary reads one code higher.
  function automatic logic [15:0] level(input logic [1:0] s, input logic a);
    logic [15:0] v;
    v = (s == SEL_ZERO) ? 16'h0123 : (s == SEL_FULL) ? 16'hf000 : pin_word;
    return v + {15'h0000, a};
  endfunction
  // Result timer; it restarts while both converters stand idle.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 3'h0;
    end else if (!run_pri && !run_aux) begin
      cnt_r <= 3'h0;
    end else begin
      cnt_r <= cnt_r + 3'h1;
    end
  end
  // One result every eight cycles; the word changes in between.
  always_comb begin
    sample_pri.valid = run_pri && cnt_r == 3'h7;
    sample_aux.valid = run_aux && cnt_r == 3'h7;
    sample_pri.word = sample_pri.valid ? level(mod_sel_pri, 1'b0) :
      {13'h0, cnt_r};
    sample_aux.word = sample_aux.valid ? level(mod_sel_aux, 1'b1) :
      ~{13'h0, cnt_r};
  end
endmodule

// File: test_adc_calibration_control.sv
// Self-checking bench of the converter calibration control.
`timescale 1ns/1ps
module test_adc_calibration_control
  import adcc_pkg::*;
;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, s;
  logic [1:0] htrans = 2'h0, mod_sel_pri, mod_sel_aux;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, missing_ref = 1'b0, run_pri, run_aux;
  logic [7:0] filter_rate;
  logic [15:0] pin_word = 16'h0000;
  adcc_coef_t factory_pri = '{16'h0011, 16'h8000};
  adcc_coef_t factory_aux = '{16'h0022, 16'h8000};
  adcc_sample_t sample_pri, sample_aux;
  int n_errors = 0, checked = 0;

  adcc_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .factory_pri(factory_pri),
    .factory_aux(factory_aux), .sample_pri(sample_pri),
    .sample_aux(sample_aux), .missing_ref(missing_ref),
    .mod_sel_pri(mod_sel_pri), .mod_sel_aux(mod_sel_aux),
    .filter_rate(filter_rate), .run_pri(run_pri), .run_aux(run_aux));
  adcc_filt_model u_model (.clk(hclk), .rstn(hresetn), .run_pri(run_pri),
    .run_aux(run_aux), .mod_sel_pri(mod_sel_pri), .mod_sel_aux(mod_sel_aux),
    .pin_word(pin_word), .sample_pri(sample_pri), .sample_aux(sample_aux));

  // Free running 100 MHz clock.
  always #5 hclk = ~hclk;

  // One single word transfer; read data is taken at the data phase end.
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string n);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    chk(n, e, q);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  // Clears the flags, starts a mode and polls until the flags appear.
  task automatic go(input logic [31:0] m, input logic [31:0] mask);
    logic [31:0] q;
    ahb(1'b1, ADDR_STAT, 32'h0000001b, q);
    ahb(1'b1, ADDR_MODE, m, q);
    for (int i = 0; i < 60; i++) begin
      ahb(1'b0, ADDR_STAT, 32'h0, q);
      if ((q & mask) === mask) break;
    end
    chk("status flags", mask, q & mask);
  endtask
  task automatic finish_test();
    if (n_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake; go gives up on a flag after 60 polls.
  initial begin
    #300000;
    n_errors++;
    finish_test();
  end
  // Main sequence of register accesses and calibrations.
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rd(ADDR_OFS0, 32'h0011, "ofs0");
    rd(ADDR_GAIN0, 32'h8000, "gain0");
    rd(ADDR_OFS1, 32'h0022, "ofs1");
    rd(ADDR_GAIN1, 32'h8000, "gain1");
    rd(ADDR_RATE, 32'h0045, "rate");
    rd(8'h40, 32'h0, "unmapped");
    ahb(1'b1, ADDR_MODE, 32'h4, s);
    rd(ADDR_MODE, 32'h1, "mode");
    go(32'h14, 32'h1);
    rd(ADDR_OFS0, 32'h0123, "ofs0");
    rd(ADDR_OFS1, 32'h0022, "ofs1");
    rd(ADDR_DATA0, 32'h0, "data0");
    go(32'h35, 32'h3);
    rd(ADDR_GAIN0, 32'hf000, "gain0");
    rd(ADDR_GAIN1, 32'hf001, "gain1");
    pin_word <= 16'h0200;
    go(32'h16, 32'h1);
    rd(ADDR_OFS0, 32'h0200, "ofs0");
    missing_ref <= 1'b1;
    go(32'h17, 32'h9);
    rd(ADDR_GAIN0, 32'hf000, "gain0");
    missing_ref <= 1'b0;
    pin_word <= 16'h0a00;
    go(32'h12, 32'h1);
    rd(ADDR_DATA0, 32'h0100, "data0");
    finish_test();
  end
endmodule

bind adcc_top adcc_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .mod_sel_pri(mod_sel_pri), .mod_sel_aux(mod_sel_aux),
  .filter_rate(filter_rate), .run_pri(run_pri), .run_aux(run_aux));
